//--- logic/cmd_tag_pkg.sv
// Shared constants for the sideband command link: timing, codes, command types.
// Assumes a single 50 MHz system clock on both ends of the link.
package cmd_tag_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int EXEC_TIME_NS  = 2000;   // Duration of the long-running command
  localparam int EXEC_CYCLES   = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMEOUT_NS    = 50000;  // Host gives up on a response after this
  localparam int TIMEOUT_CYCLES = TIMEOUT_NS / CLK_PERIOD_NS;

  // Tag values
  localparam logic [7:0] TAG_NONE  = 8'h00;  // Notifications only
  localparam logic [7:0] TAG_FIRST = 8'h01;
  localparam logic [7:0] TAG_LAST  = 8'hff;

  // Command types
  localparam logic [7:0] CMD_ECHO = 8'h01;  // Returns its data, idempotent
  localparam logic [7:0] CMD_SET  = 8'h02;  // Writes the configuration word
  localparam logic [7:0] CMD_GET  = 8'h03;  // Reads the configuration word
  localparam logic [7:0] CMD_SLOW = 8'h04;  // Long write, answered by polling
  localparam logic [7:0] RSP_FLAG = 8'h80;  // Response type is command type with this bit
  localparam logic [7:0] AEN_TYPE = 8'hff;

  // Response codes
  localparam logic [15:0] CODE_OK          = 16'h0000;
  localparam logic [15:0] CODE_FAILED      = 16'h0001;
  localparam logic [15:0] CODE_UNSUPPORTED = 16'h0003;
  localparam logic [15:0] CODE_DELAYED     = 16'h0004;

  // Reason codes
  localparam logic [15:0] REASON_NONE     = 16'h0000;
  localparam logic [15:0] REASON_BAD_TAG  = 16'h0001;
  localparam logic [15:0] REASON_NO_CMD   = 16'h0002;
  localparam logic [15:0] REASON_BUSY     = 16'h0003;
  localparam logic [15:0] REASON_DELAYED  = 16'h0004;
  localparam logic [15:0] REASON_UNKNOWN  = 16'h7fff;

  // Reset values and hints
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [15:0] POLL_HINT    = 16'h0010;  // Suggested poll interval, microseconds

endpackage

//--- logic/cmd_link_if.sv
// Command and response link between the management host and the device end.
// Both ends share SYS_CLK; the testbench instantiates and joins them.
`timescale 1ns/1ps
interface cmd_link_if;
  logic        cmd_valid;
  logic        cmd_ready;
  logic [7:0]  cmd_tag;
  logic [7:0]  cmd_type;
  logic        cmd_poll;
  logic [15:0] cmd_data;
  logic        rsp_valid;
  logic        rsp_ready;
  logic        rsp_aen;
  logic [7:0]  rsp_tag;
  logic [7:0]  rsp_type;
  logic [15:0] rsp_code;
  logic [15:0] rsp_reason;
  logic [15:0] rsp_data;

  modport device (
    input  cmd_valid, cmd_tag, cmd_type, cmd_poll, cmd_data, rsp_ready,
    output cmd_ready, rsp_valid, rsp_aen, rsp_tag, rsp_type, rsp_code, rsp_reason, rsp_data
  );
  modport host (
    output cmd_valid, cmd_tag, cmd_type, cmd_poll, cmd_data, rsp_ready,
    input  cmd_ready, rsp_valid, rsp_aen, rsp_tag, rsp_type, rsp_code, rsp_reason, rsp_data
  );
endinterface

//--- logic/host_cmd_issuer.sv
// Management host end: issues one command at a time, assigns tags, times out.
// Assumes the device end on the link modport and a user that waits for DONE.
`timescale 1ns/1ps
module host_cmd_issuer (
  input  wire logic     SYS_CLK,
  input  wire logic     RST_N,
  cmd_link_if.host      LINK,
  input  wire logic        REQ_VALID,
  output logic             REQ_READY,
  input  wire logic [7:0]  REQ_TYPE,
  input  wire logic [15:0] REQ_DATA,
  input  wire logic        REQ_RETRY,
  input  wire logic        REQ_POLL,
  output logic             DONE,
  output logic             TIMEOUT,
  output logic [7:0]       DONE_TAG,
  output logic [15:0]      DONE_CODE,
  output logic [15:0]      DONE_REASON,
  output logic [15:0]      DONE_DATA,
  output logic             AEN_SEEN,
  output logic [15:0]      AEN_DATA
);

  typedef enum logic [1:0] {H_IDLE = 2'b00, H_SEND = 2'b01, H_WAIT = 2'b11} hstate_t;

  hstate_t     state;
  logic [7:0]  tag;
  logic [7:0]  next_tag;
  logic [11:0] wait_count;
  logic        take;
  logic        rsp_match;

  ////////////////////////////////////////////////////////////////////////////
  // Handshakes
  assign REQ_READY      = (state == H_IDLE);
  assign take           = REQ_VALID && REQ_READY;
  assign LINK.cmd_valid = (state == H_SEND);
  assign LINK.rsp_ready = 1'b1;  // Host always sinks responses and notifications
  assign rsp_match      = LINK.rsp_valid && !LINK.rsp_aen && (LINK.rsp_tag == tag);

  // Next fresh tag skips zero on wrap
  assign next_tag = (tag == cmd_tag_pkg::TAG_LAST) ? cmd_tag_pkg::TAG_FIRST
                                                   : tag + 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencing: one outstanding, wait for answer or timeout
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      state      <= H_IDLE;
      wait_count <= 12'h000;
    end else begin
      unique case (state)
        H_IDLE: begin
          if (take) begin
            state <= H_SEND;
          end
        end
        H_SEND: begin
          if (LINK.cmd_ready) begin
            state      <= H_WAIT;
            wait_count <= 12'(cmd_tag_pkg::TIMEOUT_CYCLES);
          end
        end
        H_WAIT: begin
          if (rsp_match || wait_count == 12'h001) begin
            state <= H_IDLE;
          end
          wait_count <= wait_count - 12'h001;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tag and command fields; retries and polls reuse the old tag
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      tag           <= cmd_tag_pkg::TAG_LAST;  // First fresh tag is 0x01
      LINK.cmd_tag  <= cmd_tag_pkg::TAG_NONE;
      LINK.cmd_type <= 8'h00;
      LINK.cmd_poll <= 1'b0;
      LINK.cmd_data <= 16'h0000;
    end else if (take) begin
      if (REQ_RETRY || REQ_POLL) begin
        LINK.cmd_tag <= tag;
      end else begin
        tag          <= next_tag;
        LINK.cmd_tag <= next_tag;
      end
      LINK.cmd_type <= REQ_TYPE;
      LINK.cmd_poll <= REQ_POLL;
      LINK.cmd_data <= REQ_DATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Results to the user; mismatched tags are stale answers and dropped
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      DONE        <= 1'b0;
      TIMEOUT     <= 1'b0;
      AEN_SEEN    <= 1'b0;
      DONE_TAG    <= 8'h00;
      DONE_CODE   <= 16'h0000;
      DONE_REASON <= 16'h0000;
      DONE_DATA   <= 16'h0000;
      AEN_DATA    <= 16'h0000;
    end else begin
      DONE     <= (state == H_WAIT) && rsp_match;
      TIMEOUT  <= (state == H_WAIT) && !rsp_match && wait_count == 12'h001;
      AEN_SEEN <= LINK.rsp_valid && LINK.rsp_aen;
      if ((state == H_WAIT) && rsp_match) begin
        DONE_TAG    <= LINK.rsp_tag;
        DONE_CODE   <= LINK.rsp_code;
        DONE_REASON <= LINK.rsp_reason;
        DONE_DATA   <= LINK.rsp_data;
      end
      if (LINK.rsp_valid && LINK.rsp_aen) begin
        AEN_DATA <= LINK.rsp_data;
      end
    end
  end

endmodule

//--- logic/dev_cmd_handler.sv
// Device end: classifies each command by its tag, answers, replays, reports polls.
// Assumes the host end on the link modport; INIT_STATE pulses on initial-state entry.
//
// Functional notes
// - tags are 8 bit, 0x01 to 0xFF valid
// - response echoes the command tag
// - same tag, no poll: replay previous response
// - poll with nothing in progress gets error
// - poll returns result, or delayed with hint
// - different tag runs as new command unless BUSY
// - initial state forgets all earlier requests
// - notifications carry tag zero
// - host gives each new command fresh tag
// - host retry reuses the original tag
// - one command at a time only
// - host keeps one command outstanding
// - every valid command gets a response
// - stored copy replaced by each response
// - unknown type gets unsupported, unknown reason
// - never initiates; notifications only when enabled
`timescale 1ns/1ps
module dev_cmd_handler (
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  cmd_link_if.device       LINK,
  input  wire logic        INIT_STATE,
  input  wire logic        AEN_ENABLE,
  input  wire logic        AEN_EVENT,
  input  wire logic [7:0]  AEN_CODE,
  output logic [15:0]      CONFIG_VALUE,
  output logic             BUSY
);

  typedef enum logic [1:0] {D_IDLE = 2'b00, D_RESP = 2'b01, D_AEN = 2'b11} dstate_t;

  dstate_t     state;
  logic        accept;
  logic        sent;
  logic        tag_valid;
  logic [7:0]  last_tag;
  logic        slow_seen;
  logic [7:0]  exec_count;
  logic [15:0] slow_value;
  logic        aen_pending;
  logic [7:0]  aen_code;
  // Stored copy of the previous response
  logic [7:0]  st_type;
  logic [15:0] st_code;
  logic [15:0] st_reason;
  logic [15:0] st_data;
  // Combinational answer to the command being taken
  logic        match;
  logic [7:0]  next_type;
  logic [15:0] next_code;
  logic [15:0] next_reason;
  logic [15:0] next_data;
  logic        next_record;
  logic        start_slow;
  logic        do_set;

  ////////////////////////////////////////////////////////////////////////////
  // Handshakes: one command in flight until its response leaves
  assign LINK.cmd_ready = (state == D_IDLE);
  assign accept         = LINK.cmd_valid && LINK.cmd_ready;
  assign LINK.rsp_valid = (state != D_IDLE);
  assign sent           = LINK.rsp_valid && LINK.rsp_ready;
  assign match          = tag_valid && (LINK.cmd_tag == last_tag);

  ////////////////////////////////////////////////////////////////////////////
  // Classify and build the answer
  always_comb begin
    next_type   = LINK.cmd_type | cmd_tag_pkg::RSP_FLAG;
    next_code   = cmd_tag_pkg::CODE_OK;
    next_reason = cmd_tag_pkg::REASON_NONE;
    next_data   = 16'h0000;
    next_record = 1'b1;
    start_slow  = 1'b0;
    do_set      = 1'b0;
    if (LINK.cmd_tag == cmd_tag_pkg::TAG_NONE) begin
      next_code   = cmd_tag_pkg::CODE_FAILED;
      next_reason = cmd_tag_pkg::REASON_BAD_TAG;
      next_record = 1'b0;
    end else if (match && !LINK.cmd_poll) begin
      next_type   = st_type;
      next_code   = st_code;
      next_reason = st_reason;
      next_data   = st_data;
    end else if (match) begin
      // Poll answers keep the polled type; the host repeats the original type
      if (!slow_seen) begin
        next_code   = cmd_tag_pkg::CODE_FAILED;
        next_reason = cmd_tag_pkg::REASON_NO_CMD;
      end else if (BUSY) begin
        next_code   = cmd_tag_pkg::CODE_DELAYED;
        next_reason = cmd_tag_pkg::REASON_DELAYED;
        next_data   = cmd_tag_pkg::POLL_HINT;
      end else begin
        next_data = slow_value;
      end
    end else if (BUSY) begin
      // Temporal order: nothing new runs while the long write is pending
      next_code   = cmd_tag_pkg::CODE_FAILED;
      next_reason = cmd_tag_pkg::REASON_BUSY;
    end else begin
      // Fresh command
      unique case (LINK.cmd_type)
        cmd_tag_pkg::CMD_ECHO: next_data = LINK.cmd_data;
        cmd_tag_pkg::CMD_SET: begin
          do_set    = 1'b1;
          next_data = LINK.cmd_data;
        end
        cmd_tag_pkg::CMD_GET: next_data = CONFIG_VALUE;
        cmd_tag_pkg::CMD_SLOW: begin
          start_slow  = 1'b1;
          next_code   = cmd_tag_pkg::CODE_DELAYED;
          next_reason = cmd_tag_pkg::REASON_DELAYED;
          next_data   = cmd_tag_pkg::POLL_HINT;
        end
        default: begin
          next_code   = cmd_tag_pkg::CODE_UNSUPPORTED;
          next_reason = cmd_tag_pkg::REASON_UNKNOWN;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link sequencing; commands beat pending notifications
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      state <= D_IDLE;
    end else begin
      unique case (state)
        D_IDLE: begin
          if (accept) begin
            state <= D_RESP;
          end else if (aen_pending && AEN_ENABLE) begin
            state <= D_AEN;
          end
        end
        D_RESP, D_AEN: begin
          if (sent) begin
            state <= D_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response register; data outputs come from flops
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      LINK.rsp_aen    <= 1'b0;
      LINK.rsp_tag    <= cmd_tag_pkg::TAG_NONE;
      LINK.rsp_type   <= 8'h00;
      LINK.rsp_code   <= cmd_tag_pkg::CODE_OK;
      LINK.rsp_reason <= cmd_tag_pkg::REASON_NONE;
      LINK.rsp_data   <= 16'h0000;
    end else if (state == D_IDLE && accept) begin
      LINK.rsp_aen    <= 1'b0;
      LINK.rsp_tag    <= LINK.cmd_tag;
      LINK.rsp_type   <= next_type;
      LINK.rsp_code   <= next_code;
      LINK.rsp_reason <= next_reason;
      LINK.rsp_data   <= next_data;
    end else if (state == D_IDLE && aen_pending && AEN_ENABLE) begin
      LINK.rsp_aen    <= 1'b1;
      LINK.rsp_tag    <= cmd_tag_pkg::TAG_NONE;
      LINK.rsp_type   <= cmd_tag_pkg::AEN_TYPE;
      LINK.rsp_code   <= cmd_tag_pkg::CODE_OK;
      LINK.rsp_reason <= cmd_tag_pkg::REASON_NONE;
      LINK.rsp_data   <= {8'h00, aen_code};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stored copy follows every response actually sent, never a notification
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      st_type   <= 8'h00;
      st_code   <= cmd_tag_pkg::CODE_OK;
      st_reason <= cmd_tag_pkg::REASON_NONE;
      st_data   <= 16'h0000;
    end else if (state == D_RESP && sent) begin
      st_type   <= LINK.rsp_type;
      st_code   <= LINK.rsp_code;
      st_reason <= LINK.rsp_reason;
      st_data   <= LINK.rsp_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request record; initial-state entry wipes it even mid-command
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      tag_valid <= 1'b0;
      last_tag  <= cmd_tag_pkg::TAG_NONE;
    end else if (INIT_STATE) begin
      tag_valid <= 1'b0;
    end else if (accept && next_record) begin
      tag_valid <= 1'b1;
      last_tag  <= LINK.cmd_tag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration word written by the quick and the long command
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      CONFIG_VALUE <= cmd_tag_pkg::CONFIG_RESET;
    end else if (accept && do_set) begin
      CONFIG_VALUE <= LINK.cmd_data;
    end else if (BUSY && exec_count == 8'h01) begin
      CONFIG_VALUE <= slow_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Long command execution; a poll finds it busy until the count runs out
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      BUSY       <= 1'b0;
      slow_seen  <= 1'b0;
      exec_count <= 8'h00;
      slow_value <= 16'h0000;
    end else begin
      if (accept && start_slow) begin
        BUSY       <= 1'b1;
        slow_seen  <= 1'b1;
        exec_count <= 8'(cmd_tag_pkg::EXEC_CYCLES);
        slow_value <= LINK.cmd_data;
      end else begin
        if (BUSY) begin
          exec_count <= exec_count - 8'h01;
          BUSY       <= (exec_count != 8'h01);
        end
        // A fresh command, poll bit set or not, or a reset of the record ends the poll window
        if (INIT_STATE || (accept && next_record && !match && !BUSY)) begin
          slow_seen <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Notification pending flag: a new event wins over the clear on send
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      aen_pending <= 1'b0;
      aen_code    <= 8'h00;
    end else begin
      if (AEN_EVENT && AEN_ENABLE) begin
        aen_pending <= 1'b1;
        aen_code    <= AEN_CODE;
      end else if (!AEN_ENABLE || (state == D_AEN && sent)) begin
        aen_pending <= 1'b0;
      end
    end
  end

endmodule

//--- verification/cmd_link_checker.sv
// Checker for the command link between the host end and the device end.
// Assumes one clock and a synchronous active-low reset shared by both ends.
`timescale 1ns/1ps
module cmd_link_checker (
  input wire logic        SYS_CLK,
  input wire logic        RST_N,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic [7:0]  cmd_tag,
  input wire logic [7:0]  cmd_type,
  input wire logic        cmd_poll,
  input wire logic [15:0] cmd_data,
  input wire logic        rsp_valid,
  input wire logic        rsp_ready,
  input wire logic        rsp_aen,
  input wire logic [7:0]  rsp_tag,
  input wire logic [7:0]  rsp_type
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  ////////////////////////////////////////////////////////////////////////////
  // Named steps of a transfer
  sequence s_take;
    cmd_valid && cmd_ready;
  endsequence
  sequence s_sent;
    rsp_valid && rsp_ready;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // Every taken command is answered in the very next cycle
  a_take_gets_answer: assert property (s_take |=> rsp_valid && !rsp_aen)
    else $error("command taken but no response one cycle later");
  a_tag_echoed: assert property (s_take |=> rsp_tag == $past(cmd_tag))
    else $error("response tag differs from command tag");
  a_type_flagged: assert property (s_take |=> rsp_type == ($past(cmd_type) | 8'h80))
    else $error("response type is not the command type with flag");
  // Only one command at a time: no taking while an answer is out
  a_busy_refuses: assert property (rsp_valid |-> !cmd_ready)
    else $error("command ready while a response is pending");
  a_answer_once: assert property (s_sent |=> !rsp_valid)
    else $error("response stands after its handshake");
  // Notifications are not responses, so they never carry a command tag
  a_aen_tag_zero: assert property (rsp_valid && rsp_aen |-> rsp_tag == 8'h00)
    else $error("notification with nonzero tag");
  a_aen_type: assert property (rsp_valid && rsp_aen |-> rsp_type == 8'hff && !cmd_ready)
    else $error("notification with wrong type or during command");
  // Host side: legal tags only, request held until taken
  a_tag_nonzero: assert property (cmd_valid |-> cmd_tag != 8'h00)
    else $error("host offered tag zero");
  a_cmd_held: assert property (cmd_valid && !cmd_ready |=>
                               cmd_valid && $stable(cmd_tag) && $stable(cmd_data))
    else $error("host changed an offered command before it was taken");
  a_no_overlap: assert property (s_take |=> !cmd_valid)
    else $error("host offered a second command before the answer");
endmodule

//--- verification/sideband_command_tag_handler_tb.sv
// Testbench joining the host end and the device end across the link interface.
// Assumes the package constants; drives all user inputs on the falling edge.
`timescale 1ns/1ps
module sideband_command_tag_handler_tb;
  logic        sys_clk;
  logic        rst_n;
  logic        req_valid, req_ready, req_retry, req_poll, done, timeout, aen_seen;
  logic [7:0]  req_type, done_tag, aen_code, exp_tag;
  logic [15:0] req_data, done_code, done_reason, done_data, aen_data, config_value;
  logic        init_state, aen_enable, aen_event, busy;
  int          n_errors, tests_run;
  int          n_timeouts = 0;

  cmd_link_if link ();

  host_cmd_issuer i_host_cmd_issuer (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .LINK(link), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .REQ_TYPE(req_type), .REQ_DATA(req_data), .REQ_RETRY(req_retry),
    .REQ_POLL(req_poll), .DONE(done), .TIMEOUT(timeout), .DONE_TAG(done_tag),
    .DONE_CODE(done_code), .DONE_REASON(done_reason), .DONE_DATA(done_data),
    .AEN_SEEN(aen_seen), .AEN_DATA(aen_data));

  dev_cmd_handler i_dev_cmd_handler (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .LINK(link), .INIT_STATE(init_state),
    .AEN_ENABLE(aen_enable), .AEN_EVENT(aen_event), .AEN_CODE(aen_code),
    .CONFIG_VALUE(config_value), .BUSY(busy));

  cmd_link_checker i_cmd_link_checker (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready),
    .cmd_tag(link.cmd_tag), .cmd_type(link.cmd_type), .cmd_poll(link.cmd_poll),
    .cmd_data(link.cmd_data), .rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready),
    .rsp_aen(link.rsp_aen), .rsp_tag(link.rsp_tag), .rsp_type(link.rsp_type));

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 50 MHz
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timeout is a one-cycle pulse, so it is counted over the whole run
  always @(negedge sys_clk) begin
    if (rst_n === 1'b1 && timeout !== 1'b0) n_timeouts++;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reporting
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("Checks made %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // One request through the host end; a lost handshake ends the run
  task automatic send(input logic [7:0] t, input logic [15:0] d, input logic r, input logic p);
    int i;
    for (i = 0; i < 50 && req_ready !== 1'b1; i++) @(negedge sys_clk);
    if (req_ready !== 1'b1) begin
      check("req_ready", 16'h0001, {15'h0000, req_ready});
      finish_test();
    end
    req_type  = t;
    req_data  = d;
    req_retry = r;
    req_poll  = p;
    req_valid = 1'b1;
    @(negedge sys_clk);
    req_valid = 1'b0;
    // Fresh commands move the tag on, skipping zero after 0xff
    if (!(r || p)) exp_tag = (exp_tag == 8'hff) ? 8'h01 : exp_tag + 8'h01;
    for (i = 0; i < 3000 && done !== 1'b1; i++) @(negedge sys_clk);
    if (done !== 1'b1) begin
      check("done", 16'h0001, {15'h0000, done});
      finish_test();
    end
    check("done_tag", {8'h00, exp_tag}, {8'h00, done_tag});
  endtask

  task automatic chk_rsp(input logic [15:0] c, input logic [15:0] r, input logic [15:0] d);
    check("done_code", c, done_code);
    check("done_reason", r, done_reason);
    check("done_data", d, done_data);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_fresh();
    logic [7:0] bad [4] = '{8'h00, 8'h05, 8'h7f, 8'hfe};
    send(cmd_tag_pkg::CMD_ECHO, 16'h1234, 1'b0, 1'b0);
    chk_rsp(cmd_tag_pkg::CODE_OK, cmd_tag_pkg::REASON_NONE, 16'h1234);
    send(cmd_tag_pkg::CMD_SET, 16'hbeef, 1'b0, 1'b0);
    check("config_value", 16'hbeef, config_value);
    send(cmd_tag_pkg::CMD_GET, 16'h0000, 1'b0, 1'b0);
    chk_rsp(cmd_tag_pkg::CODE_OK, cmd_tag_pkg::REASON_NONE, 16'hbeef);
    foreach (bad[k]) begin
      send(bad[k], 16'h0000, 1'b0, 1'b0);
      check("done_code", cmd_tag_pkg::CODE_UNSUPPORTED, done_code);
      check("done_reason", cmd_tag_pkg::REASON_UNKNOWN, done_reason);
    end
  endtask

  // Retry must not run the write again and must return the newest answer
  task automatic t_retry();
    send(cmd_tag_pkg::CMD_SET, 16'h1111, 1'b0, 1'b0);
    send(cmd_tag_pkg::CMD_SET, 16'h2222, 1'b0, 1'b0);
    send(cmd_tag_pkg::CMD_SET, 16'h3333, 1'b1, 1'b0);
    chk_rsp(cmd_tag_pkg::CODE_OK, cmd_tag_pkg::REASON_NONE, 16'h2222);
    check("config_value", 16'h2222, config_value);
  endtask

  task automatic t_poll_idle();
    send(cmd_tag_pkg::CMD_ECHO, 16'h0005, 1'b0, 1'b0);
    send(cmd_tag_pkg::CMD_ECHO, 16'h0005, 1'b0, 1'b1);
    check("done_code", cmd_tag_pkg::CODE_FAILED, done_code);
    check("done_reason", cmd_tag_pkg::REASON_NO_CMD, done_reason);
  endtask

  task automatic t_slow();
    int i;
    send(cmd_tag_pkg::CMD_SLOW, 16'h4321, 1'b0, 1'b0);
    chk_rsp(cmd_tag_pkg::CODE_DELAYED, cmd_tag_pkg::REASON_DELAYED, cmd_tag_pkg::POLL_HINT);
    check("busy", 16'h0001, {15'h0000, busy});
    send(cmd_tag_pkg::CMD_SLOW, 16'h4321, 1'b0, 1'b1);
    chk_rsp(cmd_tag_pkg::CODE_DELAYED, cmd_tag_pkg::REASON_DELAYED, cmd_tag_pkg::POLL_HINT);
    for (i = 0; i < 200 && busy !== 1'b0; i++) @(negedge sys_clk);
    check("busy", 16'h0000, {15'h0000, busy});
    send(cmd_tag_pkg::CMD_SLOW, 16'h4321, 1'b0, 1'b1);
    chk_rsp(cmd_tag_pkg::CODE_OK, cmd_tag_pkg::REASON_NONE, 16'h4321);
    check("config_value", 16'h4321, config_value);
  endtask

  // After the initial state a repeated tag is a new command, so the write happens
  task automatic t_init();
    send(cmd_tag_pkg::CMD_SET, 16'h0abc, 1'b0, 1'b0);
    init_state = 1'b1;
    @(negedge sys_clk);
    init_state = 1'b0;
    send(cmd_tag_pkg::CMD_SET, 16'h0def, 1'b1, 1'b0);
    chk_rsp(cmd_tag_pkg::CODE_OK, cmd_tag_pkg::REASON_NONE, 16'h0def);
    check("config_value", 16'h0def, config_value);
  endtask

  task automatic t_aen();
    int i, seen;
    aen_enable = 1'b1;
    aen_code   = 8'h5a;
    aen_event  = 1'b1;
    @(negedge sys_clk);
    aen_event = 1'b0;
    for (i = 0; i < 20 && aen_seen !== 1'b1; i++) @(negedge sys_clk);
    check("aen_seen", 16'h0001, {15'h0000, aen_seen});
    check("aen_data", 16'h005a, aen_data);
    aen_enable = 1'b0;
    aen_code   = 8'h33;
    aen_event  = 1'b1;
    @(negedge sys_clk);
    aen_event = 1'b0;
    seen = 0;
    for (i = 0; i < 20; i++) begin
      @(negedge sys_clk);
      if (aen_seen !== 1'b0) seen++;
    end
    check("aen_disabled", 16'h0000, seen[15:0]);
  endtask

  // Enough fresh commands to wrap the tag past 0xff
  task automatic t_wrap();
    for (int i = 0; i < 300; i++) begin
      send(cmd_tag_pkg::CMD_ECHO, i[15:0], 1'b0, 1'b0);
      check("done_data", i[15:0], done_data);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    n_errors   = 0;
    tests_run  = 0;
    exp_tag    = 8'h00;
    rst_n      = 1'b0;
    req_valid  = 1'b0;
    req_retry  = 1'b0;
    req_poll   = 1'b0;
    req_type   = 8'h00;
    req_data   = 16'h0000;
    init_state = 1'b0;
    aen_enable = 1'b0;
    aen_event  = 1'b0;
    aen_code   = 8'h00;
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    check("config_reset", cmd_tag_pkg::CONFIG_RESET, config_value);
    check("busy_reset", 16'h0000, {15'h0000, busy});
    t_fresh();
    t_retry();
    t_poll_idle();
    t_slow();
    t_init();
    t_aen();
    t_wrap();
    check("timeout", 16'h0000, {15'h0000, timeout});
    check("timeout_count", 16'h0000, n_timeouts[15:0]);
    finish_test();
  end
endmodule
